// [core/pcrc_pkg.sv]
package pcrc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
  localparam logic [4:0] ADDR_TERMS_LOW = 5'h08;
  localparam logic [4:0] ADDR_TERMS_HIGH = 5'h0c;
  localparam logic [4:0] ADDR_DATA_IN = 5'h10;
  localparam logic [4:0] ADDR_RESULT = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 15;
  localparam int POS_COUNT = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SEL = 5;
  localparam int BIT_START = 4;
  localparam int BIT_LSB_FIRST = 3;
  localparam int POS_DATA_WIDTH_FIELD = 8;
  localparam int POS_POLY_LENGTH_FIELD = 0;

  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] RESET_FIELD = 5'h00;

  typedef struct packed {
    logic waitReq;
    logic [31:0] rdData;
    logic irq;
    logic enable;
    logic irqSel;
    logic start;
    logic lsbFirst;
    logic [4:0] dataWidth;
    logic [4:0] polyLen;
    logic [31:0] terms;
    logic [31:0] remainder;
    logic [31:0] word;
    logic [4:0] bitsLeft;
    logic busy;
    logic [FIFO_DEPTH-1:0][31:0] fifo;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0] count;
  } pcrc_state_t;

endpackage : pcrc_pkg

// [core/pcrc_generator.sv]
// Contract
// - Polynomials of order 1 to 32 supported
// - Length field sits in bits 4:0
// - Set term bit XORs feedback there
// - Clear term bit passes remainder bit through
// - Bit zero always gets feedback XOR
// - Top term implied, used as feedback tap
// - Selectable shift direction per data word
// - Data width and length set independently
// - Interrupt condition selected by software
// - Polynomial length is field plus one
// - Bits per word is width plus one
// - Select one means LSB first
// - Interrupt on FIFO empty or done
`timescale 1ns/1ps
module pcrc_generator
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic crcIrq
);

  pcrc_pkg::pcrc_state_t st_ff;
  pcrc_pkg::pcrc_state_t nxt_st;

  logic [31:0] laneMask;
  logic [31:0] wrMerged;
  logic [31:0] lenMask;
  logic [31:0] headWord;
  logic [31:0] curWord;
  logic dataBit;
  logic feedback;
  logic stepEn;
  logic loadEn;
  logic lastBit;
  logic drained;
  logic pushEn;
  logic fifoFull;
  logic fifoEmpty;
  logic accept;
  logic [31:0] nextRem;

  // ----------------------------------------------------------------
  // Bus and datapath helpers
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      laneMask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // Short polynomials keep only their low bits; 5'd31 - len never underflows
  assign lenMask = 32'hffff_ffff >> (5'd31 - st_ff.polyLen);
  assign fifoFull = st_ff.count == (pcrc_pkg::PTR_W+1)'(pcrc_pkg::FIFO_DEPTH);
  assign fifoEmpty = st_ff.count == '0;
  assign accept = !st_ff.waitReq && (avs_read || avs_write);
  assign pushEn = accept && avs_write && avs_address == pcrc_pkg::ADDR_DATA_IN && !fifoFull && st_ff.enable;
  assign headWord = st_ff.fifo[st_ff.rdPtr];
  // A fresh word is taken and its first bit shifted in the same cycle
  assign loadEn = st_ff.enable && st_ff.start && !st_ff.busy && !fifoEmpty;
  assign stepEn = loadEn || (st_ff.enable && st_ff.start && st_ff.busy);
  assign curWord = loadEn ? headWord : st_ff.word;
  assign dataBit = st_ff.lsbFirst ? curWord[0] : curWord[st_ff.dataWidth];
  assign feedback = st_ff.remainder[st_ff.polyLen] ^ dataBit;
  assign lastBit = loadEn ? (st_ff.dataWidth == '0) : (st_ff.bitsLeft == 5'd1);
  // Nothing left after this step; a one-bit word popped now also drains the FIFO
  assign drained = fifoEmpty || (loadEn && st_ff.count == (pcrc_pkg::PTR_W+1)'(1));

  always_comb
  begin
    nextRem = (st_ff.remainder << 1) & lenMask;
    if (feedback)
    begin
      nextRem = nextRem ^ ((st_ff.terms | 32'h0000_0001) & lenMask);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    wrMerged = 32'h0000_0000;
    // One wait cycle per access so read data always come from a flop
    nxt_st.waitReq = !(st_ff.waitReq && (avs_read || avs_write));
    if (st_ff.waitReq && avs_read)
    begin
      case (avs_address)
        pcrc_pkg::ADDR_CTRL_ONE:
        begin
          nxt_st.rdData = '0;
          nxt_st.rdData[pcrc_pkg::BIT_ENABLE] = st_ff.enable;
          nxt_st.rdData[pcrc_pkg::POS_COUNT +: 5] = 5'(st_ff.count);
          nxt_st.rdData[pcrc_pkg::BIT_FULL] = fifoFull;
          nxt_st.rdData[pcrc_pkg::BIT_EMPTY] = fifoEmpty;
          nxt_st.rdData[pcrc_pkg::BIT_IRQ_SEL] = st_ff.irqSel;
          nxt_st.rdData[pcrc_pkg::BIT_START] = st_ff.start;
          nxt_st.rdData[pcrc_pkg::BIT_LSB_FIRST] = st_ff.lsbFirst;
        end
        pcrc_pkg::ADDR_CTRL_TWO:
        begin
          nxt_st.rdData = '0;
          nxt_st.rdData[pcrc_pkg::POS_DATA_WIDTH_FIELD +: 5] = st_ff.dataWidth;
          nxt_st.rdData[pcrc_pkg::POS_POLY_LENGTH_FIELD +: 5] = st_ff.polyLen;
        end
        pcrc_pkg::ADDR_TERMS_LOW: nxt_st.rdData = {16'h0000, st_ff.terms[15:1], 1'b0};
        pcrc_pkg::ADDR_TERMS_HIGH: nxt_st.rdData = {16'h0000, st_ff.terms[31:16]};
        pcrc_pkg::ADDR_RESULT: nxt_st.rdData = st_ff.remainder & lenMask;
        default: nxt_st.rdData = 32'h0000_0000;
      endcase
    end

    // Engine: one bit per clock while started
    if (stepEn)
    begin
      nxt_st.remainder = nextRem;
      nxt_st.busy = !lastBit;
      if (loadEn)
      begin
        nxt_st.rdPtr = st_ff.rdPtr + 1'b1;
        nxt_st.bitsLeft = st_ff.dataWidth;
        // Source select one: last word has left the FIFO, still shifting
        if (st_ff.irqSel && st_ff.count == 1 && !pushEn)
        begin
          nxt_st.irq = 1'b1;
        end
      end
      else
      begin
        nxt_st.bitsLeft = st_ff.bitsLeft - 1'b1;
      end
      nxt_st.word = st_ff.lsbFirst ? curWord >> 1 : curWord << 1;
      if (lastBit && !st_ff.irqSel && drained)
      begin
        nxt_st.irq = 1'b1;
      end
      if (loadEn && !st_ff.lsbFirst)
      begin
        nxt_st.word = headWord << 1;
      end
    end
    if (pushEn)
    begin
      nxt_st.fifo[st_ff.wrPtr] = avs_writedata;
      nxt_st.wrPtr = st_ff.wrPtr + 1'b1;
    end
    nxt_st.count = st_ff.count + (pcrc_pkg::PTR_W+1)'(pushEn) - (pcrc_pkg::PTR_W+1)'(loadEn);

    if (accept && avs_write)
    begin
      case (avs_address)
        pcrc_pkg::ADDR_CTRL_ONE:
        begin
          wrMerged = avs_writedata & laneMask;
          if (avs_byteenable[1])
          begin
            nxt_st.enable = avs_writedata[pcrc_pkg::BIT_ENABLE];
          end
          if (avs_byteenable[0])
          begin
            nxt_st.irqSel = wrMerged[pcrc_pkg::BIT_IRQ_SEL];
            nxt_st.start = wrMerged[pcrc_pkg::BIT_START];
            nxt_st.lsbFirst = wrMerged[pcrc_pkg::BIT_LSB_FIRST];
          end
        end
        pcrc_pkg::ADDR_CTRL_TWO:
        begin
          if (avs_byteenable[1])
          begin
            nxt_st.dataWidth = avs_writedata[pcrc_pkg::POS_DATA_WIDTH_FIELD +: 5];
          end
          if (avs_byteenable[0])
          begin
            nxt_st.polyLen = avs_writedata[pcrc_pkg::POS_POLY_LENGTH_FIELD +: 5];
          end
        end
        pcrc_pkg::ADDR_TERMS_LOW:
        begin
          wrMerged = (avs_writedata & laneMask) | ({16'h0000, st_ff.terms[15:0]} & ~laneMask);
          nxt_st.terms[15:0] = {wrMerged[15:1], 1'b0};
        end
        pcrc_pkg::ADDR_TERMS_HIGH:
        begin
          wrMerged = (avs_writedata & laneMask) | ({16'h0000, st_ff.terms[31:16]} & ~laneMask);
          nxt_st.terms[31:16] = wrMerged[15:0];
        end
        // Writing the result seeds the remainder
        pcrc_pkg::ADDR_RESULT: nxt_st.remainder = (avs_writedata & laneMask) | (st_ff.remainder & ~laneMask);
        default: wrMerged = 32'h0000_0000;
      endcase
    end

    // Disabled: engine, pointers and remainder cleared, settings kept
    if (!st_ff.enable)
    begin
      nxt_st.remainder = pcrc_pkg::RESET_WORD;
      nxt_st.word = pcrc_pkg::RESET_WORD;
      nxt_st.busy = 1'b0;
      nxt_st.bitsLeft = pcrc_pkg::RESET_FIELD;
      nxt_st.wrPtr = '0;
      nxt_st.rdPtr = '0;
      nxt_st.count = '0;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      st_ff.waitReq <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata = st_ff.rdData;
  assign avs_waitrequest = st_ff.waitReq;
  assign crcIrq = st_ff.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bus_answer: assert property (@(posedge clock) disable iff (!arst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_result_masked: assert property (@(posedge clock) disable iff (!arst_n)
    avs_read && avs_waitrequest && avs_address == pcrc_pkg::ADDR_RESULT |=> (avs_readdata & ~$past(lenMask)) == 0)
    else $error("result shows bits above polynomial length");
  a_const_term: assert property (@(posedge clock) disable iff (!arst_n)
    stepEn && st_ff.enable && !(accept && avs_write && avs_address == pcrc_pkg::ADDR_RESULT) |=>
    st_ff.remainder[0] == $past(feedback))
    else $error("bit zero missed the feedback");
  a_term_xor: assert property (@(posedge clock) disable iff (!arst_n)
    stepEn && feedback && !(accept && avs_write) |=>
    st_ff.remainder == ((($past(st_ff.remainder) << 1) ^ ($past(st_ff.terms) | 32'h1)) & $past(lenMask)))
    else $error("feedback not applied at set terms");
  a_term_pass: assert property (@(posedge clock) disable iff (!arst_n)
    stepEn && !feedback && !(accept && avs_write) |=>
    st_ff.remainder == (($past(st_ff.remainder) << 1) & $past(lenMask)))
    else $error("clear term altered remainder");
  a_word_bits: assert property (@(posedge clock) disable iff (!arst_n)
    loadEn && st_ff.dataWidth == 5'd7 && !(accept && avs_write) |=> st_ff.busy [*7] ##1 !st_ff.busy)
    else $error("word not shifted for width plus one bits");
  a_lsb_order: assert property (@(posedge clock) disable iff (!arst_n)
    loadEn |-> dataBit == (st_ff.lsbFirst ? headWord[0] : headWord[st_ff.dataWidth]))
    else $error("first bit taken from wrong end");
  a_irq_cause: assert property (@(posedge clock) disable iff (!arst_n)
    crcIrq |-> $past(stepEn) && ($past(st_ff.irqSel) ? $past(loadEn) : $past(lastBit && drained)))
    else $error("interrupt without its selected cause");
  a_fifo_bound: assert property (@(posedge clock) disable iff (!arst_n)
    st_ff.count <= (pcrc_pkg::PTR_W+1)'(pcrc_pkg::FIFO_DEPTH))
    else $error("fifo count past depth");

endmodule : pcrc_generator

// [verification/pcrc_generator_test.sv]
`timescale 1ns/1ps
module pcrc_generator_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic crcIrq;
  int error_cnt = 0;
  int n_tests = 0;
  int irqCnt = 0;
  logic [31:0] rd;

  always #50 clock = ~clock;

  pcrc_generator dut_u (.clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crcIrq(crcIrq));

  // Pulse is one full cycle wide, so the falling edge sees it exactly once
  always @(negedge clock)
    if (crcIrq === 1'b1)
      irqCnt++;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waitrequest is looked at mid-cycle so the completing rising edge is known race-free
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(negedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    // Completing edge: read data hold across it, so they are taken here
    @(posedge clock);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus

  // ----------------------------------------------------------------
  // Reference shift engine
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_word(input logic [31:0] rem, input logic [31:0] d, input int w,
    input int p, input logic [31:0] t, input logic lsb);
    logic [31:0] m;
    logic fb;
    m = 32'hffffffff >> (31 - p);
    for (int i = 0; i <= w; i++)
    begin
      fb = rem[p] ^ (lsb ? d[i] : d[w - i]);
      rem = (rem << 1) & m;
      if (fb)
        rem = rem ^ ((t | 32'h1) & m);
    end
    return rem;
  endfunction : crc_word

  task automatic run_case(input int p, input int w, input logic [31:0] t, input logic lsb, input logic isel,
    input int n);
    logic [31:0] exp;
    logic [31:0] c;
    logic [31:0] d;
    int k0;
    exp = 32'h0;
    c = {16'h0, 1'b1, 9'h0, isel, 1'b1, lsb, 3'h0};
    bus(1'b1, pcrc_pkg::ADDR_CTRL_ONE, 32'h0, rd);
    bus(1'b1, pcrc_pkg::ADDR_CTRL_ONE, 32'h8000, rd);
    bus(1'b1, pcrc_pkg::ADDR_CTRL_TWO, 32'((w << 8) | p), rd);
    bus(0, pcrc_pkg::ADDR_CTRL_TWO, 32'h0, rd);
    check("ctrl2", rd, 32'((w << 8) | p));
    bus(1'b1, pcrc_pkg::ADDR_TERMS_LOW, t & 32'hffff, rd);
    bus(1'b1, pcrc_pkg::ADDR_TERMS_HIGH, t >> 16, rd);
    for (int k = 0; k < n; k++)
    begin
      d = (32'h9e3779b9 * 32'(k + 3)) ^ 32'(p);
      bus(1'b1, pcrc_pkg::ADDR_DATA_IN, d, rd);
      if (k < 8)
        exp = crc_word(exp, d, w, p, t, lsb);
    end
    bus(0, pcrc_pkg::ADDR_CTRL_ONE, 32'h0, rd);
    check("fifo", rd, 32'h8000 | 32'(((n > 8 ? 8 : n) << 8)) | (n >= 8 ? 32'h80 : 32'h0));
    k0 = irqCnt;
    bus(1'b1, pcrc_pkg::ADDR_CTRL_ONE, c, rd);
    for (int i = 0; i < 400 && irqCnt == k0; i++)
      @(posedge clock);
    repeat (w + 4) @(posedge clock);
    check("irq", 32'(irqCnt - k0), 32'h1);
    bus(0, pcrc_pkg::ADDR_RESULT, 32'h0, rd);
    check("result", rd, exp);
    bus(0, pcrc_pkg::ADDR_CTRL_ONE, 32'h0, rd);
    check("ctrl1", rd, c | 32'h40);
  endtask : run_case

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(0, pcrc_pkg::ADDR_RESULT, 32'h0, rd);
    check("result reset", rd, 32'h0);
    bus(1'b1, pcrc_pkg::ADDR_TERMS_LOW, 32'h0000ffff, rd);
    bus(0, pcrc_pkg::ADDR_TERMS_LOW, 32'h0, rd);
    check("terms low", rd, 32'h0000fffe);
    bus(1'b1, pcrc_pkg::ADDR_TERMS_HIGH, 32'h0000abcd, rd);
    bus(0, pcrc_pkg::ADDR_TERMS_HIGH, 32'h0, rd);
    check("terms high", rd, 32'h0000abcd);
    bus(1'b1, 5'h18, 32'hffffffff, rd);
    bus(0, 5'h18, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    bus(0, pcrc_pkg::ADDR_DATA_IN, 32'h0, rd);
    check("data in", rd, 32'h0);
    run_case(15, 7, 32'h1021, 1'b0, 1'b0, 3);
    run_case(15, 7, 32'h1021, 1'b1, 1'b1, 3);
    run_case(31, 31, 32'h04c11db7, 1'b0, 1'b0, 2);
    run_case(3, 31, 32'h2, 1'b1, 1'b1, 9);
    run_case(0, 0, 32'h0, 1'b0, 1'b0, 5);
    bus(1'b1, pcrc_pkg::ADDR_CTRL_TWO, 32'h0000_001f, rd);
    bus(1'b1, pcrc_pkg::ADDR_RESULT, 32'h1234_5678, rd);
    bus(0, pcrc_pkg::ADDR_RESULT, 32'h0, rd);
    check("result seed", rd, 32'h1234_5678);
    end_of_test();
  end
endmodule : pcrc_generator_test
